//--- rtl/mbx_exec.sv
// Execution unit for multiply, compare, skip, branch, jump and call instructions
//
// Contract
// RULE1: self_and_test ANDs Rd with itself, updates Z N V only, one cycle.
// RULE2: Integer multiplies write 16-bit product to R1:R0, update Z C, two cycles.
// RULE3: Fractional multiplies shift product left one, update Z C, two cycles.
// RULE4: indirect_jump loads PC from Z pointer, flags unchanged, two cycles.
// RULE5: indirect_subroutine_call pushes return address, PC from Z, four cycles.
// RULE6: compare_skip_equal skips next instruction when equal; one to three cycles.
// RULE7: Compares set Z N V C H only, write no register, one cycle.
// RULE8: Register bit skips skip on bit clear or set, one to three cycles.
// RULE9: I/O bit skips test an I/O bit, skip on clear or set.
// RULE10: Generic flag branches jump PC+k+1 on selected flag; one or two cycles.
// RULE11: Same-or-higher taken on carry clear, lower on carry set.
// RULE12: Signed branches use N xor V: zero for ge, one for lt.
// RULE13: Half carry branches taken on H one or zero, PC+k+1.
// RULE14: Transfer bit branch taken when T is one, flags unchanged.
// RULE15: Carry branches taken on carry set or clear, else sequential.
// RULE16: Decrement, clear by self xor, fill ones without flags; one cycle each.
// RULE17: Jump and call cycle counts; interrupt exit also sets I.
// RULE18: Equal/not-equal test Z, minus/plus test N; one or two cycles.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module mbx_exec #(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_busy
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  if (STACK_DEPTH < 2 || STACK_DEPTH > 8 || (1 << SP_W) != STACK_DEPTH) begin : g_chk
    $error("STACK_DEPTH must be a power of two from 2 to 8");
  end

  logic                 aw_full;
  logic                 w_full;
  logic [7:0]           wr_addr;
  logic [31:0]          wr_data;
  logic [3:0]           wr_strb;
  logic                 wr_do;
  logic                 go;
  logic                 go_refused;
  logic                 known_w;
  mbx_pkg::mbx_opnd_type opnd;
  logic [15:0]          pc;
  logic [15:0]          k_rel;
  logic [31:0]          ptr;
  mbx_pkg::mbx_flags_type flg;
  logic [7:0]           io_val;
  logic [7:0]           res;
  logic [15:0]          prod;
  logic [2:0]           cnt;
  logic [2:0]           last_cyc;
  logic [15:0]          stk [STACK_DEPTH];
  logic [SP_W-1:0]      sp;
  mbx_pkg::mbx_op_type  op;
  logic [7:0]           rd;
  logic [7:0]           src;
  logic [8:0]           sub;
  logic [7:0]           minus_one;
  logic [15:0]          pr_uu;
  logic [15:0]          pr_ss;
  logic [15:0]          pr_su;
  logic [15:0]          br_tgt;
  logic [15:0]          skip_tgt;
  logic [15:0]          next_pc;
  mbx_pkg::mbx_flags_type next_flg;
  logic [7:0]           next_res;
  logic [15:0]          next_prod;
  logic [2:0]           next_cyc;
  logic                 next_push;
  logic                 next_pop;
  logic [15:0]          back_addr;
  logic                 cond;
  logic [15:0]          raw;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  assign wr_do      = aw_full && w_full && !o_bvalid;
  assign known_w    = wr_addr == mbx_pkg::OFS_CMD || wr_addr == mbx_pkg::OFS_OPND ||
                      wr_addr == mbx_pkg::OFS_PC || wr_addr == mbx_pkg::OFS_PTR ||
                      wr_addr == mbx_pkg::OFS_FLAGS || wr_addr == mbx_pkg::OFS_IO;
  // A new instruction written before the previous one has used up its cycles is refused with a slave error
  assign go_refused = wr_do && wr_addr == mbx_pkg::OFS_CMD && (o_busy || !wr_strb[0]);
  assign go         = wr_do && wr_addr == mbx_pkg::OFS_CMD && !o_busy && wr_strb[0];
  assign op         = mbx_pkg::mbx_op_type'(wr_data[mbx_pkg::POS_OP +: 6]);

  // Write address and data channels, taken in either order
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= mbx_pkg::RESP_OKAY;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h0000_0000;
      wr_strb   <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full   <= 1'b1;
        o_awready <= 1'b0;
        wr_addr   <= {i_awaddr[7:2], 2'b00};
      end
      if (i_wvalid && o_wready) begin
        w_full   <= 1'b1;
        o_wready <= 1'b0;
        wr_data  <= i_wdata;
        wr_strb  <= i_wstrb;
      end
      if (wr_do) begin
        o_bvalid <= 1'b1;
        o_bresp  <= !known_w ? mbx_pkg::RESP_DEC : go_refused ? mbx_pkg::RESP_SLV : mbx_pkg::RESP_OKAY;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        aw_full   <= 1'b0;
        w_full    <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // Read channel, one outstanding read
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= mbx_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= mbx_pkg::RESP_OKAY;
      case ({i_araddr[7:2], 2'b00})
        mbx_pkg::OFS_CMD:   o_rdata <= 32'h0000_0000;
        mbx_pkg::OFS_OPND:  o_rdata <= opnd;
        mbx_pkg::OFS_PC:    o_rdata <= {k_rel, pc};
        mbx_pkg::OFS_PTR:   o_rdata <= ptr;
        mbx_pkg::OFS_FLAGS: o_rdata <= {24'h00_0000, flg};
        mbx_pkg::OFS_IO:    o_rdata <= {24'h00_0000, io_val};
        mbx_pkg::OFS_RES:   o_rdata <= {prod, 8'h00, res};
        mbx_pkg::OFS_STAT:  o_rdata <= {24'h00_0000, 4'(sp), last_cyc, o_busy};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= mbx_pkg::RESP_DEC;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Operand registers written by software only
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      opnd   <= '0;
      ptr    <= 32'h0000_0000;
      io_val <= 8'h00;
    end else if (wr_do) begin
      if (wr_addr == mbx_pkg::OFS_OPND) opnd <= merge(opnd, wr_data, wr_strb);
      if (wr_addr == mbx_pkg::OFS_PTR) ptr <= merge(ptr, wr_data, wr_strb);
      if (wr_addr == mbx_pkg::OFS_IO && wr_strb[0]) io_val <= wr_data[7:0];
    end
  end

  assign rd       = opnd.rd;
  assign src      = opnd.rr;
  assign sub      = {1'b0, rd} - {1'b0, src} - {8'h00, op == mbx_pkg::OP_COMPARE_WITH_BORROW && flg.c};
  assign minus_one = rd - 8'h01;
  assign pr_uu    = {8'h00, rd} * {8'h00, src};
  assign pr_ss    = 16'($signed(rd) * $signed(src));
  assign pr_su    = 16'($signed({rd[7], rd}) * $signed({1'b0, src}));
  assign br_tgt   = pc + k_rel + 16'h0001;
  assign skip_tgt = pc + (opnd.two_word ? 16'h0003 : 16'h0002);

  // Branch condition by opcode
  always_comb begin
    cond = 1'b0;
    case (op)
      // RULE10 selected status bit
      mbx_pkg::OP_BRANCH_FLAG_SET:         cond = flg[opnd.flag_sel];
      mbx_pkg::OP_BRANCH_FLAG_CLEAR:       cond = !flg[opnd.flag_sel];
      // RULE18 zero and negative
      mbx_pkg::OP_BRANCH_EQUAL:            cond = flg[mbx_pkg::FLG_Z];
      mbx_pkg::OP_BRANCH_NOT_EQUAL:        cond = !flg[mbx_pkg::FLG_Z];
      mbx_pkg::OP_BRANCH_MINUS:            cond = flg[mbx_pkg::FLG_N];
      mbx_pkg::OP_BRANCH_PLUS:             cond = !flg[mbx_pkg::FLG_N];
      // RULE15 carry set or clear
      mbx_pkg::OP_BRANCH_CARRY_SET:        cond = flg[mbx_pkg::FLG_C];
      mbx_pkg::OP_BRANCH_CARRY_CLEAR:      cond = !flg[mbx_pkg::FLG_C];
      // RULE11 unsigned ordering
      mbx_pkg::OP_BRANCH_SAME_OR_HIGHER:   cond = !flg[mbx_pkg::FLG_C];
      mbx_pkg::OP_BRANCH_LOWER:            cond = flg[mbx_pkg::FLG_C];
      // RULE12 signed ordering
      mbx_pkg::OP_BRANCH_SIGNED_GE:        cond = !(flg.n ^ flg.v);
      mbx_pkg::OP_BRANCH_SIGNED_LT:        cond = flg.n ^ flg.v;
      // RULE13 half carry
      mbx_pkg::OP_BRANCH_HALF_CARRY_SET:   cond = flg[mbx_pkg::FLG_H];
      mbx_pkg::OP_BRANCH_HALF_CARRY_CLEAR: cond = !flg[mbx_pkg::FLG_H];
      // RULE14 transfer bit
      mbx_pkg::OP_BRANCH_TRANSFER_BIT_SET: cond = flg[mbx_pkg::FLG_T];
      // RULE6 equal registers
      mbx_pkg::OP_COMPARE_SKIP_EQUAL:      cond = rd == src;
      // RULE8 register bit
      mbx_pkg::OP_SKIP_REG_BIT_CLEAR:      cond = !rd[opnd.bit_sel[2:0]];
      mbx_pkg::OP_SKIP_REG_BIT_SET:        cond = rd[opnd.bit_sel[2:0]];
      // RULE9 I/O bit
      mbx_pkg::OP_SKIP_IO_BIT_CLEAR:       cond = !io_val[opnd.bit_sel[2:0]];
      mbx_pkg::OP_SKIP_IO_BIT_SET:         cond = io_val[opnd.bit_sel[2:0]];
      default:                             cond = 1'b0;
    endcase
  end

  // Results of the instruction in the command write
  always_comb begin
    next_pc   = pc + 16'h0001;
    next_flg  = flg;
    next_res  = res;
    next_prod = prod;
    next_cyc  = mbx_pkg::CYC_ONE;
    next_push = 1'b0;
    next_pop  = 1'b0;
    back_addr = pc + 16'h0001;
    raw       = 16'h0000;
    case (op)
      // RULE16 decrement
      mbx_pkg::OP_COUNT_DOWN_ONE: begin
        next_res   = minus_one;
        next_flg.z = minus_one == 8'h00;
        next_flg.n = minus_one[7];
        next_flg.v = rd == mbx_pkg::SIGN_MIN;
      end
      // RULE1 self and
      mbx_pkg::OP_SELF_AND_TEST: begin
        next_res   = rd & rd;
        next_flg.z = (rd & rd) == 8'h00;
        next_flg.n = rd[7];
        next_flg.v = 1'b0;
      end
      // RULE16 clear by self xor
      mbx_pkg::OP_ZERO_REGISTER: begin
        next_res   = rd ^ rd;
        next_flg.z = 1'b1;
        next_flg.n = 1'b0;
        next_flg.v = 1'b0;
      end
      // RULE16 fill, flags kept
      mbx_pkg::OP_FILL_ONES: next_res = 8'hFF;
      // RULE2 integer products
      // RULE3 fractional products shifted
      mbx_pkg::OP_PRODUCT_UNSIGNED, mbx_pkg::OP_PRODUCT_SIGNED, mbx_pkg::OP_PRODUCT_SIGNED_BY_UNSIGNED,
      mbx_pkg::OP_FRACTION_PRODUCT_UNSIGNED, mbx_pkg::OP_FRACTION_PRODUCT_SIGNED,
      mbx_pkg::OP_FRACTION_PRODUCT_MIXED: begin
        raw = (op == mbx_pkg::OP_PRODUCT_UNSIGNED || op == mbx_pkg::OP_FRACTION_PRODUCT_UNSIGNED) ? pr_uu :
              (op == mbx_pkg::OP_PRODUCT_SIGNED || op == mbx_pkg::OP_FRACTION_PRODUCT_SIGNED) ? pr_ss : pr_su;
        next_prod  = op >= mbx_pkg::OP_FRACTION_PRODUCT_UNSIGNED ? {raw[14:0], 1'b0} : raw;
        next_flg.c = raw[15];
        next_flg.z = next_prod == 16'h0000;
        next_cyc   = mbx_pkg::CYC_PROD;
      end
      // RULE17 relative and direct jumps
      mbx_pkg::OP_RELATIVE_JUMP: begin
        next_pc  = br_tgt;
        next_cyc = mbx_pkg::CYC_REL_J;
      end
      mbx_pkg::OP_DIRECT_JUMP: begin
        next_pc  = ptr[31:16];
        next_cyc = mbx_pkg::CYC_JMP;
      end
      // RULE4 pointer jump
      mbx_pkg::OP_INDIRECT_JUMP: begin
        next_pc  = ptr[15:0];
        next_cyc = mbx_pkg::CYC_PTR_J;
      end
      // RULE17 relative call
      mbx_pkg::OP_RELATIVE_SUBROUTINE_CALL: begin
        next_pc   = br_tgt;
        next_push = 1'b1;
        next_cyc  = mbx_pkg::CYC_CALL_S;
      end
      // RULE5 pointer call
      mbx_pkg::OP_INDIRECT_SUBROUTINE_CALL: begin
        next_pc   = ptr[15:0];
        next_push = 1'b1;
        next_cyc  = mbx_pkg::CYC_CALL_S;
      end
      // RULE17 two-word call returns past its address word
      mbx_pkg::OP_DIRECT_CALL: begin
        next_pc   = ptr[31:16];
        back_addr = pc + 16'h0002;
        next_push = 1'b1;
        next_cyc  = mbx_pkg::CYC_LONG;
      end
      // RULE17 returns; interrupt exit enables interrupts
      mbx_pkg::OP_ROUTINE_EXIT, mbx_pkg::OP_INTERRUPT_EXIT: begin
        next_pc    = stk[sp - SP_W'(1)];
        next_pop   = 1'b1;
        next_cyc   = mbx_pkg::CYC_LONG;
        next_flg.i = op == mbx_pkg::OP_INTERRUPT_EXIT ? 1'b1 : flg.i;
      end
      // RULE7 subtract for flags only
      mbx_pkg::OP_COMPARE, mbx_pkg::OP_COMPARE_WITH_BORROW, mbx_pkg::OP_COMPARE_IMMEDIATE: begin
        next_flg.n = sub[7];
        next_flg.c = sub[8];
        next_flg.h = (!rd[3] && src[3]) || (src[3] && sub[3]) || (sub[3] && !rd[3]);
        next_flg.v = (rd[7] && !src[7] && !sub[7]) || (!rd[7] && src[7] && sub[7]);
        // Borrow form keeps zero across a multi-byte compare
        next_flg.z = sub[7:0] == 8'h00 && (op != mbx_pkg::OP_COMPARE_WITH_BORROW || flg.z);
      end
      // RULE6 RULE8 RULE9 skip over one- or two-word instruction
      mbx_pkg::OP_COMPARE_SKIP_EQUAL, mbx_pkg::OP_SKIP_REG_BIT_CLEAR, mbx_pkg::OP_SKIP_REG_BIT_SET,
      mbx_pkg::OP_SKIP_IO_BIT_CLEAR, mbx_pkg::OP_SKIP_IO_BIT_SET: begin
        next_pc  = cond ? skip_tgt : pc + 16'h0001;
        next_cyc = !cond ? mbx_pkg::CYC_ONE : opnd.two_word ? mbx_pkg::CYC_SKIP2 : mbx_pkg::CYC_SKIP1;
      end
      default: begin
        // RULE10 taken branch costs one extra cycle
        next_pc  = cond ? br_tgt : pc + 16'h0001;
        next_cyc = cond ? mbx_pkg::CYC_TAKEN : mbx_pkg::CYC_ONE;
      end
    endcase
  end

  // Program counter and relative offset
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc    <= mbx_pkg::RST_PC;
      k_rel <= 16'h0000;
    end else if (go) begin
      pc <= next_pc;
    end else if (wr_do && wr_addr == mbx_pkg::OFS_PC) begin
      {k_rel, pc} <= merge({k_rel, pc}, wr_data, wr_strb);
    end
  end

  // Status flags
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flg <= mbx_pkg::RST_FLAGS;
    end else if (go) begin
      flg <= next_flg;
    end else if (wr_do && wr_addr == mbx_pkg::OFS_FLAGS && wr_strb[0]) begin
      flg <= wr_data[7:0];
    end
  end

  // Result byte and R1:R0 product
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      res  <= 8'h00;
      prod <= 16'h0000;
    end else if (go) begin
      res  <= next_res;
      prod <= next_prod;
    end
  end

  // Return stack; overflow wraps and overwrites the oldest entry
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sp <= '0;
      for (int e = 0; e < STACK_DEPTH; e++) begin
        stk[e] <= 16'h0000;
      end
    end else if (go && next_push) begin
      stk[sp] <= back_addr;
      sp      <= sp + SP_W'(1);
    end else if (go && next_pop) begin
      sp <= sp - SP_W'(1);
    end
  end

  // Busy covers every cycle after the first
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt      <= 3'h0;
      o_busy   <= 1'b0;
      last_cyc <= 3'h0;
    end else if (go) begin
      cnt      <= next_cyc - 3'h1;
      o_busy   <= next_cyc != mbx_pkg::CYC_ONE;
      last_cyc <= next_cyc;
    end else if (o_busy) begin
      cnt    <= cnt - 3'h1;
      o_busy <= cnt != 3'h1;
    end
  end

  property p_test_one;
    @(posedge i_mclk) disable iff (!i_rst_b)
    go && op == mbx_pkg::OP_SELF_AND_TEST |=> !o_busy && res == $past(rd) && flg.c == $past(flg.c);
  endproperty
  a_test_one: assert property (p_test_one) else $error("self test wrong"); // RULE1

  property p_prod_two;
    @(posedge i_mclk) disable iff (!i_rst_b)
    go && op == mbx_pkg::OP_PRODUCT_UNSIGNED |=> o_busy && prod == $past(pr_uu) ##1 !o_busy;
  endproperty
  a_prod_two: assert property (p_prod_two) else $error("multiply wrong"); // RULE2

  property p_frac_shift;
    @(posedge i_mclk) disable iff (!i_rst_b)
    go && op == mbx_pkg::OP_FRACTION_PRODUCT_SIGNED |=>
      prod == {$past(pr_ss[14:0]), 1'b0} && flg.c == $past(pr_ss[15]);
  endproperty
  a_frac_shift: assert property (p_frac_shift) else $error("fraction product wrong"); // RULE3

  property p_ptr_jump;
    @(posedge i_mclk) disable iff (!i_rst_b)
    go && op == mbx_pkg::OP_INDIRECT_JUMP |=> pc == $past(ptr[15:0]) && flg == $past(flg) ##1 !o_busy;
  endproperty
  a_ptr_jump: assert property (p_ptr_jump) else $error("indirect jump wrong"); // RULE4

  property p_indirect_subroutine_call;
    @(posedge i_mclk) disable iff (!i_rst_b)
    go && op == mbx_pkg::OP_INDIRECT_SUBROUTINE_CALL |=> o_busy[*3] ##1 !o_busy;
  endproperty
  a_indirect_subroutine_call: assert property (p_indirect_subroutine_call) else $error("indirect call length wrong"); // RULE5

  property p_skip_equal;
    @(posedge i_mclk) disable iff (!i_rst_b)
    go && op == mbx_pkg::OP_COMPARE_SKIP_EQUAL && rd == src && opnd.two_word |=> pc == $past(pc) + 16'h0003;
  endproperty
  a_skip_equal: assert property (p_skip_equal) else $error("skip distance wrong"); // RULE6

  property p_cmp;
    @(posedge i_mclk) disable iff (!i_rst_b)
    go && op == mbx_pkg::OP_COMPARE |=> res == $past(res) && flg.z == ($past(rd) == $past(src)) && !o_busy;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrong"); // RULE7

  property p_signed_ge;
    @(posedge i_mclk) disable iff (!i_rst_b)
    go && op == mbx_pkg::OP_BRANCH_SIGNED_GE && !(flg.n ^ flg.v) |=> pc == $past(br_tgt) && o_busy;
  endproperty
  a_signed_ge: assert property (p_signed_ge) else $error("signed branch wrong"); // RULE12

  property p_int_exit;
    @(posedge i_mclk) disable iff (!i_rst_b)
    go && op == mbx_pkg::OP_INTERRUPT_EXIT |=> flg.i ##0 o_busy[*4] ##1 !o_busy;
  endproperty
  a_int_exit: assert property (p_int_exit) else $error("interrupt exit wrong"); // RULE17
endmodule : mbx_exec

//--- rtl/mbx_pkg.sv
// Package: register map, field layout, opcodes and cycle counts of the execution unit
package mbx_pkg;
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  OFS_CMD    = 8'h00;
  localparam logic [7:0]  OFS_OPND   = 8'h04;
  localparam logic [7:0]  OFS_PC     = 8'h08;
  localparam logic [7:0]  OFS_PTR    = 8'h0C;
  localparam logic [7:0]  OFS_FLAGS  = 8'h10;
  localparam logic [7:0]  OFS_IO     = 8'h14;
  localparam logic [7:0]  OFS_RES    = 8'h18;
  localparam logic [7:0]  OFS_STAT   = 8'h1C;
  localparam int          POS_OP     = 0;
  localparam int          POS_K      = 16;
  localparam int          POS_PROD   = 16;
  localparam int          POS_BUSY   = 0;
  localparam int          POS_CYC    = 1;
  localparam int          POS_SP     = 4;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  localparam logic [1:0]  RESP_DEC   = 2'h3;
  localparam logic [7:0]  RST_FLAGS  = 8'h00;
  localparam logic [15:0] RST_PC     = 16'h0000;
  localparam logic [7:0]  SIGN_MIN   = 8'h80;
  localparam logic [2:0]  CYC_ONE    = 3'h1;
  localparam logic [2:0]  CYC_PROD   = 3'h2;
  localparam logic [2:0]  CYC_REL_J  = 3'h2;
  localparam logic [2:0]  CYC_PTR_J  = 3'h2;
  localparam logic [2:0]  CYC_JMP    = 3'h3;
  localparam logic [2:0]  CYC_CALL_S = 3'h4;
  localparam logic [2:0]  CYC_LONG   = 3'h5;
  localparam logic [2:0]  CYC_TAKEN  = 3'h2;
  localparam logic [2:0]  CYC_SKIP1  = 3'h2;
  localparam logic [2:0]  CYC_SKIP2  = 3'h3;
  localparam logic [2:0]  FLG_C = 3'h0;
  localparam logic [2:0]  FLG_Z = 3'h1;
  localparam logic [2:0]  FLG_N = 3'h2;
  localparam logic [2:0]  FLG_H = 3'h5;
  localparam logic [2:0]  FLG_T = 3'h6;

  typedef enum logic [5:0] {
    OP_COUNT_DOWN_ONE, OP_SELF_AND_TEST, OP_ZERO_REGISTER, OP_FILL_ONES,
    OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_SIGNED_BY_UNSIGNED,
    OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED,
    OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_DIRECT_JUMP, OP_RELATIVE_SUBROUTINE_CALL,
    OP_INDIRECT_SUBROUTINE_CALL, OP_DIRECT_CALL, OP_ROUTINE_EXIT, OP_INTERRUPT_EXIT,
    OP_COMPARE_SKIP_EQUAL, OP_COMPARE, OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER, OP_BRANCH_LOWER,
    OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR, OP_BRANCH_TRANSFER_BIT_SET
  } mbx_op_type;

  typedef struct packed {
    logic i, t, h, s, v, n, z, c;
  } mbx_flags_type;

  // Operand word: next instruction length, flag select, bit select, Rr or K, Rd
  typedef struct packed {
    logic [7:0] unused;
    logic       two_word;
    logic [2:0] flag_sel;
    logic [3:0] bit_sel;
    logic [7:0] rr;
    logic [7:0] rd;
  } mbx_opnd_type;
endpackage : mbx_pkg

//--- test/tb.sv
// Self-checking bench for the multiply, compare, skip and branch unit
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb;
  logic        i_mclk = 1'h0, i_rst_b = 1'h0;
  logic [7:0]  i_awaddr = 8'h0, i_araddr = 8'h0;
  logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_arvalid = 1'h0;
  logic        i_bready = 1'h1, i_rready = 1'h1;
  logic [31:0] i_wdata = 32'h0, rv;
  logic [3:0]  i_wstrb = 4'hF;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_busy, t;
  logic [1:0]  o_bresp, o_rresp, resp;
  logic [31:0] o_rdata;
  logic [7:0]  a, b, f;
  logic [15:0] k, pc;
  logic [2:0]  s;
  int          num_errors = 0, cmp_count = 0, cyc = 0, op;
  int          one_op [5] = '{0, 19, 20, 2, 3}, seq_op [6] = '{13, 14, 17, 16, 10, 12};
  logic [15:0] one_opnd [5] = '{16'h2080, 16'h0910, 16'h2010, 16'h005A, 16'h005A};
  logic [15:0] one_exp [5] = '{16'h7F08, 16'h7F20, 16'h7F05, 16'h0003, 16'hFF03};
  logic [15:0] seq_pc [6] = '{16'h0051, 16'h0200, 16'h0052, 16'h0041, 16'h0052, 16'h0300};
  logic [2:0]  seq_cyc [6] = '{3'h4, 3'h4, 3'h5, 3'h5, 3'h2, 3'h3};
  mbx_exec uut (.i_mclk, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .o_busy);
  always #5 i_mclk = ~i_mclk;
  // Cuts a hang short
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // Ready signals held high; master releases each channel once taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    i_awaddr <= ad;
    i_wdata <= d;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    forever begin
      @(posedge i_mclk);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
      if (o_bvalid) break;
    end
    resp = o_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    i_araddr <= ad;
    i_arvalid <= 1'h1;
    forever begin
      @(posedge i_mclk);
      if (o_arready) i_arvalid <= 1'h0;
      if (o_rvalid) break;
    end
    rv = o_rdata;
    resp = o_rresp;
  endtask : rd
  task automatic run(input int c);
    wr(mbx_pkg::OFS_CMD, 32'(c));
    while (o_busy) @(posedge i_mclk);
  endtask : run
  function automatic logic [15:0] prod(int c, logic [7:0] x, logic [7:0] y);
    int          m;
    logic [17:0] p;
    m = (c - 4) % 3;
    p = $signed({(m != 0) & x[7], x}) * $signed({(m == 1) & y[7], y});
    return (c >= 7) ? {p[14:0], 1'h0} : p[15:0];
  endfunction : prod
  function automatic logic taken(int c, logic [7:0] g, logic [2:0] sel);
    case (c)
      26: return g[sel];
      27: return !g[sel];
      28: return g[1];
      29: return !g[1];
      30, 33: return g[0];
      31, 32: return !g[0];
      34: return g[2];
      35: return !g[2];
      36: return !(g[2] ^ g[3]);
      37: return g[2] ^ g[3];
      38: return g[5];
      39: return !g[5];
      default: return g[6];
    endcase
  endfunction : taken
  initial begin
    void'($urandom(32'h585F6A49));
    repeat (5) @(posedge i_mclk);
    i_rst_b <= 1'h1;
    rd(mbx_pkg::OFS_FLAGS);
    `CHK("reset flags", 32'h0, rv)
    rd(8'h20);
    `CHK("unmapped resp", 2'h3, resp)
    for (int i = 0; i < 24; i++) begin
      op = 4 + i % 6;
      a = (i < 6) ? 8'h80 : 8'($urandom);
      b = (i < 6) ? 8'h80 : 8'($urandom);
      wr(mbx_pkg::OFS_OPND, {16'h0, b, a});
      run(op);
      rd(mbx_pkg::OFS_RES);
      `CHK("product", prod(op, a, b), rv[31:16])
      rd(mbx_pkg::OFS_STAT);
      `CHK("product cycles", 3'h2, rv[3:1])
    end
    for (int i = 0; i < 75; i++) begin
      op = 26 + i % 15;
      f = 8'($urandom);
      s = 3'($urandom);
      k = 16'($urandom_range(40)) - 16'h14;
      pc = 16'($urandom);
      wr(mbx_pkg::OFS_FLAGS, {24'h0, f});
      wr(mbx_pkg::OFS_OPND, {9'h0, s, 20'h0});
      wr(mbx_pkg::OFS_PC, {k, pc});
      run(op);
      t = taken(op, f, s);
      rd(mbx_pkg::OFS_PC);
      `CHK("branch pc", t ? pc + k + 16'h1 : pc + 16'h1, rv[15:0])
      rd(mbx_pkg::OFS_STAT);
      `CHK("branch cycles", t ? 3'h2 : 3'h1, rv[3:1])
      rd(mbx_pkg::OFS_FLAGS);
      `CHK("branch flags", f, rv[7:0])
    end
    wr(mbx_pkg::OFS_FLAGS, 32'h5A);
    wr(mbx_pkg::OFS_PTR, 32'h1234);
    run(11);
    rd(mbx_pkg::OFS_PC);
    `CHK("jump pc", 16'h1234, rv[15:0])
    rd(mbx_pkg::OFS_FLAGS);
    `CHK("jump flags", 8'h5A, rv[7:0])
    wr(mbx_pkg::OFS_OPND, 32'h00803C3C);
    wr(mbx_pkg::OFS_PC, 32'h100);
    run(18);
    rd(mbx_pkg::OFS_PC);
    `CHK("skip pc", 16'h103, rv[15:0])
    wr(mbx_pkg::OFS_FLAGS, 32'h0);
    wr(mbx_pkg::OFS_OPND, 32'h80);
    run(1);
    rd(mbx_pkg::OFS_FLAGS);
    `CHK("test flags", 8'h04, rv[7:0])
    // Result byte kept by compares; flags chain from one step to the next
    wr(mbx_pkg::OFS_FLAGS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(mbx_pkg::OFS_OPND, {16'h0, one_opnd[i]});
      run(one_op[i]);
      rd(mbx_pkg::OFS_RES);
      `CHK("result byte", one_exp[i][15:8], rv[7:0])
      rd(mbx_pkg::OFS_FLAGS);
      `CHK("result flags", one_exp[i][7:0], rv[7:0])
    end
    for (int i = 0; i < 40; i++) begin
      op = (i % 5 == 0) ? 18 : 21 + i % 5;
      a = 8'($urandom);
      b = (i % 2) ? a : 8'($urandom);
      f = 8'($urandom);
      s = 3'($urandom);
      t = (op == 18) ? a == b : (op < 24 ? a[s] : f[s]) == op[0];
      wr(mbx_pkg::OFS_IO, {24'h0, f});
      wr(mbx_pkg::OFS_OPND, {8'h0, i[1], 3'h0, 1'h0, s, b, a});
      wr(mbx_pkg::OFS_PC, 32'h200);
      run(op);
      rd(mbx_pkg::OFS_PC);
      `CHK("skip distance", t ? 16'h202 + i[1] : 16'h201, rv[15:0])
      rd(mbx_pkg::OFS_STAT);
      `CHK("skip cycles", t ? 3'h2 + i[1] : 3'h1, rv[3:1])
    end
    wr(mbx_pkg::OFS_PTR, 32'h0300_0200);
    wr(mbx_pkg::OFS_PC, 32'h0010_0040);
    for (int i = 0; i < 6; i++) begin
      run(seq_op[i]);
      rd(mbx_pkg::OFS_PC);
      `CHK("flow pc", seq_pc[i], rv[15:0])
      rd(mbx_pkg::OFS_STAT);
      `CHK("flow cycles", seq_cyc[i], rv[3:1])
    end
    rd(mbx_pkg::OFS_FLAGS);
    `CHK("exit flags", 8'h83, rv[7:0])
    // Second command while the long call still runs
    wr(mbx_pkg::OFS_CMD, 32'hF);
    wr(mbx_pkg::OFS_CMD, 32'h4);
    `CHK("busy refusal", 2'h2, resp)
    while (o_busy) @(posedge i_mclk);
    close_out();
  end
endmodule : tb
